//--- rtl/pts_pkg.sv
package pts_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned DEBOUNCE_US = 10000;
   localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned BLINK_MS = 250;
   localparam int unsigned BLINK_CYC = (BLINK_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned REV_SHOW_MS = 1000;
   localparam int unsigned REV_SHOW_CYC = (REV_SHOW_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned PHASE_DWELL_CYC = 64;

   // ------------------------------------------------------------
   // Geometry and reset values
   // ------------------------------------------------------------
   localparam int unsigned RAM_AW = 8;
   localparam int unsigned DIGITS = 7;
   localparam logic [7:0] REVISION_CODE = 8'h01;
   localparam logic [15:0] CAL_SIGNATURE = 16'h5a3c;

   // Seven segment codes, bit 7 is decimal point
   localparam logic [7:0] SEG_BLANK = 8'h00;
   localparam logic [7:0] SEG_ALL = 8'hff;
   localparam logic [7:0] SEG_MINUS = 8'h40;
   localparam logic [7:0] SEG_R = 8'h50;
   localparam logic [7:0] SEG_P = 8'h73;
   localparam logic [7:0] SEG_EQ = 8'h48;
   localparam logic [7:0] SEG_0 = 8'h3f;
   localparam logic [7:0] SEG_C = 8'h39;
   localparam logic [7:0] SEG_S = 8'h6d;
   localparam logic [7:0] SEG_DP = 8'h80;
   localparam logic [7:0] SEG_ONE = 8'h06;

   typedef enum logic [1:0] {PH_ZERO, PH_REF, PH_SIG} pts_phase_t;

   typedef struct packed {
      logic [DIGITS-1:0][7:0] digit;
      logic exp_dp;
      logic all_leds;
   } pts_disp_t;

   typedef struct packed {
      logic [RAM_AW-1:0] addr;
      logic we;
      logic [7:0] wdata;
   } pts_ram_req_t;

endpackage : pts_pkg

//--- rtl/pts_key_debounce.sv
`timescale 1ns/1ns
module pts_key_debounce #(
   parameter int unsigned COUNT = pts_pkg::DEBOUNCE_CYC
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_key,
   output logic o_level,
   output logic o_press
);
   localparam int unsigned CW = $clog2(COUNT + 1);
   logic [CW-1:0] cnt;
   wire differs = (i_key != o_level);
   wire done = (cnt == CW'(COUNT - 1));

   // RULE14 - stable before accept
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cnt <= '0;
         o_level <= 1'b0;
         o_press <= 1'b0;
      end
      else
      begin
         o_press <= differs && done && i_key;
         if (!differs)
            cnt <= '0;
         else if (done)
         begin
            cnt <= '0;
            o_level <= i_key;
         end
         else
            cnt <= cnt + CW'(1);
      end
   end
endmodule : pts_key_debounce

//--- rtl/pts_selftest_seq.sv
`timescale 1ns/1ns
// Functional notes
// RULE1 - Power-up RAM test and calibration check
// RULE2 - RAM fault: show r.r., halt forever
// RULE3 - Cal fault: blink exponent points, keep running
// RULE4 - Key held at power-up enters diagnostics
// RULE5 - Key held: all LEDs and segments lit; the top digit shows only minus, one and point
// RULE6 - Key released: show firmware revision
// RULE7 - Each press advances zero, reference, signal, wrap
// RULE8 - Decimal point position shows selected range
// RULE9 - Zero phase: P=0, analog common routed
// RULE10 - Reference phase: P=C, negative reference routed
// RULE11 - Signal phase: P=S, ranging amplifier routed
// RULE12 - Diagnostics persist until power removed
// RULE13 - Normal mode cycles phases continuously
// RULE14 - Debounce key: one advance per press
module pts_selftest_seq #(
   parameter int unsigned DEBOUNCE = pts_pkg::DEBOUNCE_CYC,
   parameter int unsigned BLINK = pts_pkg::BLINK_CYC,
   parameter int unsigned REV_SHOW = pts_pkg::REV_SHOW_CYC,
   parameter int unsigned DWELL = pts_pkg::PHASE_DWELL_CYC,
   parameter logic [7:0] REVISION = pts_pkg::REVISION_CODE
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_front_trigger_key,
   input wire logic [2:0] i_range,
   input wire logic [15:0] i_cal_word,
   input wire logic [7:0] i_ram_rdata,
   output pts_pkg::pts_ram_req_t o_ram,
   output pts_pkg::pts_disp_t o_disp,
   output pts_pkg::pts_phase_t o_mux_sel,
   output logic o_normal_run,
   output logic o_ram_fault,
   output logic o_cal_fault,
   output logic o_diag_mode
);
   typedef enum logic [3:0] {
      ST_STRAP, ST_WR, ST_RD, ST_CHK, ST_CAL, ST_RAMFAIL,
      ST_LAMP, ST_REV, ST_DIAG, ST_RUN
   } pts_state_t;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] pattern(input logic [pts_pkg::RAM_AW-1:0] a, input logic inv);
      pattern = inv ? ~(8'(a) ^ 8'h55) : (8'(a) ^ 8'h55);
   endfunction : pattern

   function automatic logic [7:0] phase_glyph(input pts_pkg::pts_phase_t p);
      case (p)
         pts_pkg::PH_ZERO: phase_glyph = pts_pkg::SEG_0;
         pts_pkg::PH_REF: phase_glyph = pts_pkg::SEG_C;
         pts_pkg::PH_SIG: phase_glyph = pts_pkg::SEG_S;
         default: phase_glyph = pts_pkg::SEG_BLANK;
      endcase
   endfunction : phase_glyph

   function automatic pts_pkg::pts_phase_t phase_next(input pts_pkg::pts_phase_t p);
      case (p)
         pts_pkg::PH_ZERO: phase_next = pts_pkg::PH_REF;
         pts_pkg::PH_REF: phase_next = pts_pkg::PH_SIG;
         default: phase_next = pts_pkg::PH_ZERO;
      endcase
   endfunction : phase_next

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   localparam int unsigned TW = $clog2(((BLINK > REV_SHOW) ? BLINK : REV_SHOW) + 1);
   pts_state_t state;
   pts_state_t next_state;
   logic [pts_pkg::RAM_AW-1:0] addr;
   logic pass_inv;
   logic [TW-1:0] timer;
   logic [TW-1:0] blink_cnt;
   logic blink;
   logic cal_bad;
   pts_pkg::pts_phase_t phase;
   logic key_level;
   logic key_press;

   pts_key_debounce #(.COUNT(DEBOUNCE)) u_key (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_key(i_front_trigger_key),
      .o_level(key_level),
      .o_press(key_press)
   );

   // ------------------------------------------------------------
   // Sequencing
   // ------------------------------------------------------------
   wire addr_last = (addr == {pts_pkg::RAM_AW{1'b1}});
   wire rd_mismatch = (i_ram_rdata != pattern(addr, pass_inv));
   wire rev_done = (timer == TW'(REV_SHOW - 1));
   wire dwell_done = (timer == TW'(DWELL - 1));
   wire blink_wrap = (blink_cnt == TW'(BLINK - 1));
   wire [pts_pkg::DIGITS-1:0] dp_mask = pts_pkg::DIGITS'(1) << i_range;

   always_comb
   begin
      next_state = state;
      case (state)
         // RULE4 - sample key at power-up
         ST_STRAP: next_state = i_front_trigger_key ? ST_LAMP : ST_WR;
         // RULE1 - RAM write/read test
         ST_WR: next_state = addr_last ? ST_RD : ST_WR;
         ST_RD: next_state = ST_CHK;
         ST_CHK:
         begin
            if (rd_mismatch)
               next_state = ST_RAMFAIL;
            else if (addr_last)
               next_state = pass_inv ? ST_CAL : ST_WR;
            else
               next_state = ST_RD;
         end
         ST_CAL: next_state = ST_RUN;
         // RULE2 - no exit from fault
         ST_RAMFAIL: next_state = ST_RAMFAIL;
         // RULE5 - lamp test while held
         // Raw key bridges the debounce lag after power-up
         ST_LAMP: next_state = (key_level || i_front_trigger_key) ? ST_LAMP : ST_REV;
         // RULE6 - revision shown after release
         ST_REV: next_state = rev_done ? ST_DIAG : ST_REV;
         // RULE12 - diagnostics until power off
         ST_DIAG: next_state = ST_DIAG;
         ST_RUN: next_state = ST_RUN;
         default: next_state = ST_STRAP;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state <= ST_STRAP;
         addr <= '0;
         pass_inv <= 1'b0;
         timer <= '0;
      end
      else
      begin
         state <= next_state;
         if (state == ST_WR || state == ST_CHK)
            addr <= addr + pts_pkg::RAM_AW'(1);
         if (state == ST_CHK && addr_last)
            pass_inv <= 1'b1;
         if (state != next_state || (state == ST_RUN && dwell_done))
            timer <= '0;
         else
            timer <= timer + TW'(1);
      end
   end

   // RULE3 - cal signature check, blink timer
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cal_bad <= 1'b0;
         blink_cnt <= '0;
         blink <= 1'b0;
      end
      else
      begin
         if (state == ST_CAL)
            cal_bad <= (i_cal_word != pts_pkg::CAL_SIGNATURE);
         blink_cnt <= blink_wrap ? '0 : blink_cnt + TW'(1);
         if (blink_wrap)
            blink <= ~blink;
      end
   end

   // RULE7 - advance on debounced press
   // RULE13 - free-running phase cycle
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         phase <= pts_pkg::PH_ZERO;
      else if ((state == ST_DIAG && key_press) || (state == ST_RUN && dwell_done))
         phase <= phase_next(phase);
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   pts_pkg::pts_disp_t next_disp;
   always_comb
   begin
      next_disp = '0;
      case (state)
         ST_RAMFAIL:
         begin
            next_disp.digit[1] = pts_pkg::SEG_R | pts_pkg::SEG_DP;
            next_disp.digit[0] = pts_pkg::SEG_R | pts_pkg::SEG_DP;
         end
         ST_LAMP:
         begin
            next_disp.all_leds = 1'b1;
            next_disp.exp_dp = 1'b1;
            for (int i = 0; i < pts_pkg::DIGITS - 1; i++)
               next_disp.digit[i] = pts_pkg::SEG_ALL;
            next_disp.digit[pts_pkg::DIGITS-1] = pts_pkg::SEG_MINUS | pts_pkg::SEG_ONE | pts_pkg::SEG_DP;
         end
         ST_REV:
         begin
            next_disp.digit[1] = {1'b0, REVISION[6:0]};
            next_disp.digit[0] = {1'b0, 7'(REVISION[7])};
         end
         // RULE9 - zero phase message
         // RULE10 - reference phase message
         // RULE11 - signal phase message
         // RULE8 - range on decimal point
         ST_DIAG:
         begin
            next_disp.digit[2] = pts_pkg::SEG_P;
            next_disp.digit[1] = pts_pkg::SEG_EQ;
            next_disp.digit[0] = phase_glyph(phase);
            for (int i = 0; i < pts_pkg::DIGITS; i++)
               if (dp_mask[i])
                  next_disp.digit[i] = next_disp.digit[i] | pts_pkg::SEG_DP;
         end
         // RULE3 - blink points on cal fault
         ST_RUN: next_disp.exp_dp = cal_bad & blink;
         default: next_disp = '0;
      endcase
   end

   // Mux follows phase only once a phase is owned, common otherwise
   wire mux_live = (state == ST_DIAG) || (state == ST_RUN);

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_disp <= '0;
         o_mux_sel <= pts_pkg::PH_ZERO;
         o_ram <= '0;
         o_normal_run <= 1'b0;
         o_ram_fault <= 1'b0;
         o_cal_fault <= 1'b0;
         o_diag_mode <= 1'b0;
      end
      else
      begin
         o_disp <= next_disp;
         o_mux_sel <= mux_live ? phase : pts_pkg::PH_ZERO;
         o_ram.addr <= addr;
         o_ram.we <= (state == ST_WR);
         o_ram.wdata <= pattern(addr, pass_inv);
         o_normal_run <= (state == ST_RUN);
         o_ram_fault <= (state == ST_RAMFAIL);
         o_cal_fault <= cal_bad;
         o_diag_mode <= (state == ST_DIAG);
      end
   end
endmodule : pts_selftest_seq

//--- bench/pts_ram_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Working RAM with a stuck-bit fault
// ----------------------------------------
module pts_ram_model (
   input wire logic i_sys_clk,
   input wire logic i_stuck,
   input wire pts_pkg::pts_ram_req_t i_ram,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [256];
   always @(posedge i_sys_clk)
      if (i_ram.we) mem[i_ram.addr] <= i_ram.wdata;
   // read back, bit 0 may stick high
   assign o_rdata = mem[i_ram.addr] | {7'h0, i_stuck};
endmodule : pts_ram_model

//--- bench/pts_selftest_chk.sv
`timescale 1ns/1ns
module pts_selftest_chk #(
   parameter int unsigned BLINK = 8,
   parameter int unsigned DWELL = 4
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire pts_pkg::pts_disp_t o_disp,
   input wire pts_pkg::pts_phase_t o_mux_sel,
   input wire logic o_normal_run,
   input wire logic o_ram_fault,
   input wire logic o_cal_fault,
   input wire logic o_diag_mode
);
   localparam int BL = 2 * BLINK + 2;
   localparam int DW = 3 * DWELL + 4;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   a_fault_holds: assert property (o_ram_fault |=> o_ram_fault && !o_normal_run)
      else $error("ram fault released");
   a_diag_sticky: assert property (o_diag_mode |=> o_diag_mode && !o_normal_run)
      else $error("diag mode left");
   a_diag_excl: assert property (o_diag_mode |-> !o_ram_fault && !o_normal_run)
      else $error("diag with run or fault");
   a_phase_order: assert property ((o_normal_run || o_diag_mode) && $past(o_normal_run || o_diag_mode)
      && $changed(o_mux_sel) |-> o_mux_sel == ($past(o_mux_sel) == pts_pkg::PH_SIG ? pts_pkg::PH_ZERO
      : ($past(o_mux_sel) == pts_pkg::PH_ZERO ? pts_pkg::PH_REF : pts_pkg::PH_SIG)))
      else $error("phase out of order");
   a_run_cycles: assert property (o_normal_run && o_mux_sel == pts_pkg::PH_ZERO
      |-> ##[1:DW] o_mux_sel == pts_pkg::PH_REF) else $error("run phase stuck");
   a_cal_blink: assert property (o_cal_fault && o_normal_run |-> ##[1:BL] $changed(o_disp.exp_dp))
      else $error("exponent points not blinking");
   a_no_blink: assert property (o_normal_run && !o_cal_fault |-> !o_disp.exp_dp)
      else $error("exponent points lit");
   a_cal_runs: assert property ($rose(o_cal_fault) |-> ##[0:4] o_normal_run)
      else $error("cal fault stopped run");
   a_lamp_all: assert property (o_disp.all_leds |-> o_disp.digit[0] == pts_pkg::SEG_ALL && !o_normal_run)
      else $error("lamp test incomplete");
endmodule : pts_selftest_chk
bind pts_selftest_seq pts_selftest_chk #(.BLINK(BLINK), .DWELL(DWELL)) i_chk (.i_sys_clk, .i_rst_b, .o_disp,
   .o_mux_sel, .o_normal_run, .o_ram_fault, .o_cal_fault, .o_diag_mode);

//--- bench/pts_selftest_seq_tb.sv
`timescale 1ns/1ns
module pts_selftest_seq_tb;
   localparam int DB = 4;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic key = 1'b0;
   logic [2:0] range = 3'h0;
   logic [15:0] cal = 16'h5a3c;
   logic stuck = 1'b0;
   logic [7:0] rdata;
   logic [7:0] g;
   logic [15:0] v;
   pts_pkg::pts_ram_req_t ram;
   pts_pkg::pts_disp_t disp;
   pts_pkg::pts_phase_t mux;
   logic run, rflt, cflt, diag, found;
   int mismatches = 0;
   int num_checks = 0;
   int cyc = 0;
   int i, p, c, j, k;
   int ph_q[$];
   always #25 clk = ~clk;
   pts_selftest_seq #(.DEBOUNCE(DB), .BLINK(8), .REV_SHOW(16), .DWELL(4)) i_dut (.i_sys_clk(clk),
      .i_rst_b(rst_b), .i_front_trigger_key(key), .i_range(range), .i_cal_word(cal), .i_ram_rdata(rdata),
      .o_ram(ram), .o_disp(disp), .o_mux_sel(mux), .o_normal_run(run), .o_ram_fault(rflt),
      .o_cal_fault(cflt), .o_diag_mode(diag));
   pts_ram_model i_ram (.i_sys_clk(clk), .i_stuck(stuck), .i_ram(ram), .o_rdata(rdata));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         close_out();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // Key released at power-up waits for the self test to finish
   task power_up(input logic kv, input logic [15:0] cv, input logic sv);
      @(posedge clk);
      rst_b <= 1'b0;
      key <= kv;
      cal <= cv;
      stuck <= sv;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      i = 0;
      while (!kv && run !== 1'b1 && rflt !== 1'b1 && i < 5000)
      begin
         @(posedge clk);
         i++;
      end
      tick(5);
   endtask : power_up
   task press(input int hold);
      @(posedge clk) key <= 1'b1;
      repeat (hold) @(posedge clk);
      key <= 1'b0;
      tick(DB + 8);
   endtask : press
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'hecd298c1));
      power_up(1'b0, 16'h5a3c, 1'b0);
      check(i >= 1536, 1);
      check({rflt, cflt, diag, run}, 4'b0001);
      c = 0;
      p = mux;
      repeat (40)
      begin
         tick(1);
         if (mux !== p)
         begin
            check(mux, (p + 1) % 3);
            p = mux;
            c++;
         end
      end
      check(c > 2, 1);
      press(DB + 4);
      check({diag, run}, 2'b01);
      v = 16'($urandom);
      if (v == 16'h5a3c) v = 16'h0000;
      power_up(1'b0, v, 1'b0);
      check({cflt, run}, 2'b11);
      c = 0;
      repeat (20)
      begin
         tick(1);
         c += disp.exp_dp;
      end
      check(c > 0 && c < 20, 1);
      power_up(1'b0, 16'h5a3c, 1'b1);
      press(DB + 4);
      tick(200);
      check({rflt, run, diag}, 3'b100);
      power_up(1'b1, 16'h5a3c, 1'b0);
      tick(30);
      check({disp.all_leds, run}, 2'b10);
      check(disp.digit[0], pts_pkg::SEG_ALL);
      @(posedge clk) key <= 1'b0;
      tick(DB + 4);
      check({disp.all_leds, diag}, 2'b00);
      check(disp.digit[1], {1'b0, pts_pkg::REVISION_CODE[6:0]});
      tick(40);
      check(diag, 1);
      ph_q = {0, 1, 2};
      for (k = 0; k < 5; k++)
      begin
         @(posedge clk) range <= 3'($urandom % 7);
         tick(4);
         p = ph_q.pop_front();
         ph_q.push_back(p);
         check(mux, p);
         g = p == 0 ? pts_pkg::SEG_0 : (p == 1 ? pts_pkg::SEG_C : pts_pkg::SEG_S);
         found = 1'b0;
         for (j = 0; j < 7; j++)
            if ((disp.digit[j] & 8'h7f) == g) found = 1'b1;
         check(found, 1);
         check(disp.digit[range][7], 1);
         press(DB + 4);
      end
      press(DB - 2);
      check(mux, ph_q[0]);
      check({diag, run}, 2'b10);
      close_out();
   end
endmodule : pts_selftest_seq_tb
